// ---- pkh_pkg.sv ----
// Purpose: Shared constants for the packet handler configuration block
// Assumes: APB word addressing, register index times four gives the byte address
// Notes: Register indices keep the printed numbering
package pkh_pkg;
    localparam int ADDR_W = 12;
    // Register indices
    localparam logic [7:0] IDX_PKT_CFG = 8'h37;
    localparam logic [7:0] IDX_PAYLOAD_LEN = 8'h38;
    localparam logic [7:0] IDX_STATION_ADDR = 8'h39;
    localparam logic [7:0] IDX_GROUP_ADDR = 8'h3a;
    localparam logic [7:0] IDX_AUTO_CTRL = 8'h3b;
    localparam logic [7:0] IDX_OP_MODE = 8'h50;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h51;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h52;
    localparam logic [7:0] IDX_LIVE_STATUS = 8'h53;
    // Packet configuration field positions
    localparam int PC_LEN_KIND = 7;
    localparam int PC_LINE_HI = 6;
    localparam int PC_LINE_LO = 5;
    localparam int PC_CRC_EN = 4;
    localparam int PC_FAIL_KEEP = 3;
    localparam int PC_FILT_HI = 2;
    localparam int PC_FILT_LO = 1;
    localparam logic [7:0] PC_WR_MASK = 8'hfe;
    // Auto sequencer field positions
    localparam int AC_ENT_HI = 7;
    localparam int AC_ENT_LO = 5;
    localparam int AC_LV_HI = 4;
    localparam int AC_LV_LO = 2;
    localparam int AC_MODE_HI = 1;
    localparam int AC_MODE_LO = 0;
    // Reset values
    localparam logic [7:0] RST_PKT_CFG = 8'h10;
    localparam logic [7:0] RST_PAYLOAD_LEN = 8'h40;
    localparam logic [7:0] RST_STATION_ADDR = 8'h00;
    localparam logic [7:0] RST_GROUP_ADDR = 8'h00;
    localparam logic [7:0] RST_AUTO_CTRL = 8'h00;
    localparam logic [1:0] RST_OP_MODE = 2'h1;
    // Encodings
    localparam logic [1:0] LINE_NONE = 2'h0;
    localparam logic [1:0] LINE_MANCH = 2'h1;
    localparam logic [1:0] LINE_WHITE = 2'h2;
    localparam logic [1:0] FILT_OFF = 2'h0;
    localparam logic [1:0] FILT_OWN = 2'h1;
    localparam logic [1:0] FILT_OWN_GRP = 2'h2;
    localparam logic [2:0] TRIG_OFF = 3'h0;
    localparam logic [2:0] TRIG_QHB_RISE = 3'h1;
    localparam logic [2:0] TRIG_OVER = 3'h2;
    localparam logic [2:0] TRIG_CRC = 3'h3;
    localparam logic [2:0] TRIG_PAYLOAD = 3'h4;
    localparam logic [2:0] TRIG_MARKER = 3'h5;
    localparam logic [2:0] TRIG_TXDONE = 3'h6;
    localparam logic [2:0] TRIG_SEVEN = 3'h7;
    // Interrupt status bits
    localparam int IRQ_W = 5;
    localparam int IRQ_PAYLOAD = 0;
    localparam int IRQ_CRC_FAIL = 1;
    localparam int IRQ_DROP = 2;
    localparam int IRQ_ENTER = 3;
    localparam int IRQ_LEAVE = 4;
    typedef enum logic [0:0] {
        PKH_AUTO_IDLE = 1'b0,
        PKH_AUTO_INTERIM = 1'b1
    } pkh_auto_e;
endpackage : pkh_pkg

// ---- pkh_packet_handler.sv ----
// Purpose: Packet handler configuration, receive filtering and auto mode sequencer
// Assumes: Flag inputs are synchronous levels, event inputs are one-cycle pulses
// Notes: APB slave with one wait state on every access
`timescale 1ns/10ps
`default_nettype none

//Contract
// - Length-kind bit: 0 fixed length, 1 variable length with length byte.
// - Line code select: 00 none, 01 Manchester, 10 whitening, 11 reserved.
// - Checksum enable adds CRC on transmit and checks it on receive.
// - Fail-keep 0: failed CRC clears queue, restarts reception, no payload-complete.
// - Fail-keep 1: failed CRC keeps queue and still raises payload-complete.
// - Filter 00 off, 01 own address, 10 own or group, 11 reserved.
// - Fixed length: payload length register used both ways, reset 0x40.
// - Variable length: register is receive maximum, ignored on transmit.
// - Own station address register, reset zero, compared when filtering.
// - Group station address register, reset zero, compared in own-or-group filtering.
// - Entry trigger bits 7-5 select the flag edge entering interim mode.
// - Leave trigger bits 4-2 select the flag edge or timeout leaving.
// - Interim state field selects sleep, standby, receive or transmit.
// - Trigger code 000 switches automatic sequencing off.
// - Interim active flag set on entry, cleared on leaving.
module pkh_packet_handler
    import pkh_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic queue_has_byte,
    input wire logic queue_over_threshold,
    input wire logic frame_marker_match,
    input wire logic tx_frame_done,
    input wire logic rx_timeout,
    input wire logic rx_addr_valid,
    input wire logic [7:0] rx_addr,
    input wire logic rx_len_valid,
    input wire logic [7:0] rx_len,
    input wire logic rx_frame_end,
    input wire logic rx_crc_pass,
    output logic length_kind_select,
    output logic [1:0] line_code_select,
    output logic tx_crc_append,
    output logic rx_crc_check,
    output logic [7:0] tx_len,
    output logic [7:0] rx_max_len,
    output logic queue_clear,
    output logic rx_restart,
    output logic rx_payload_complete,
    output logic checksum_good,
    output logic [1:0] op_mode,
    output logic auto_interim_active,
    output logic irq
);
    logic [7:0] pkt_cfg_ff, payload_len_ff, station_addr_ff, group_addr_ff, auto_ctrl_ff;
    logic [1:0] sw_mode_ff, saved_mode_ff;
    logic [IRQ_W-1:0] irq_st_ff, irq_mask_ff, nxt_irq_st;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff, nxt_prdata;
    logic nxt_hit;
    logic [7:0] idx;
    logic wr_en;
    logic qhb_prev_ff, over_prev_ff, crc_prev_ff, pc_prev_ff, mark_prev_ff, txd_prev_ff;
    logic payload_ff, crc_good_ff, queue_clear_ff, restart_ff;
    logic [1:0] op_mode_ff;
    pkh_auto_e auto_state_ff;
    logic enter_ev, leave_ev, auto_on, crc_fail, drop_ev, addr_pass;
    logic [2:0] ent_code, lv_code;

    // APB: access phase held one cycle, second access cycle completes
    assign idx = paddr[9:2];
    assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;

    always_comb begin
        nxt_hit = 1'b1;
        nxt_prdata = 32'h0000_0000;
        case (idx)
            IDX_PKT_CFG: nxt_prdata[7:0] = pkt_cfg_ff;
            IDX_PAYLOAD_LEN: nxt_prdata[7:0] = payload_len_ff;
            IDX_STATION_ADDR: nxt_prdata[7:0] = station_addr_ff;
            IDX_GROUP_ADDR: nxt_prdata[7:0] = group_addr_ff;
            IDX_AUTO_CTRL: nxt_prdata[7:0] = auto_ctrl_ff;
            IDX_OP_MODE: nxt_prdata[1:0] = sw_mode_ff;
            IDX_IRQ_STATUS: nxt_prdata[IRQ_W-1:0] = irq_st_ff;
            IDX_IRQ_MASK: nxt_prdata[IRQ_W-1:0] = irq_mask_ff;
            IDX_LIVE_STATUS: nxt_prdata[3:0] = {op_mode_ff, auto_interim_active, payload_ff};
            default: nxt_hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != '0) begin
            nxt_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= !nxt_hit;
            prdata_ff <= (pwrite || !nxt_hit) ? 32'h0000_0000 : nxt_prdata;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pkt_cfg_ff <= RST_PKT_CFG;
            payload_len_ff <= RST_PAYLOAD_LEN;
            station_addr_ff <= RST_STATION_ADDR;
            group_addr_ff <= RST_GROUP_ADDR;
            auto_ctrl_ff <= RST_AUTO_CTRL;
            sw_mode_ff <= RST_OP_MODE;
            irq_mask_ff <= '0;
        end else if (wr_en) begin
            case (idx)
                IDX_PKT_CFG: pkt_cfg_ff <= pwdata[7:0] & PC_WR_MASK;
                IDX_PAYLOAD_LEN: payload_len_ff <= pwdata[7:0];
                IDX_STATION_ADDR: station_addr_ff <= pwdata[7:0];
                IDX_GROUP_ADDR: group_addr_ff <= pwdata[7:0];
                IDX_AUTO_CTRL: auto_ctrl_ff <= pwdata[7:0];
                IDX_OP_MODE: sw_mode_ff <= pwdata[1:0];
                IDX_IRQ_MASK: irq_mask_ff <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Datapath configuration outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            length_kind_select <= 1'b0;
            line_code_select <= LINE_NONE;
            tx_crc_append <= 1'b0;
            rx_crc_check <= 1'b0;
            tx_len <= RST_PAYLOAD_LEN;
            rx_max_len <= RST_PAYLOAD_LEN;
        end else begin
            length_kind_select <= pkt_cfg_ff[PC_LEN_KIND];
            // Reserved code 11 is passed on as is; software must not use it
            line_code_select <= pkt_cfg_ff[PC_LINE_HI:PC_LINE_LO];
            tx_crc_append <= pkt_cfg_ff[PC_CRC_EN];
            rx_crc_check <= pkt_cfg_ff[PC_CRC_EN];
            tx_len <= pkt_cfg_ff[PC_LEN_KIND] ? 8'h00 : payload_len_ff;
            rx_max_len <= payload_len_ff;
        end
    end

    // Receive acceptance
    always_comb begin
        case (pkt_cfg_ff[PC_FILT_HI:PC_FILT_LO])
            FILT_OWN: addr_pass = (rx_addr == station_addr_ff);
            FILT_OWN_GRP: addr_pass = (rx_addr == station_addr_ff)
                || (rx_addr == group_addr_ff);
            default: addr_pass = 1'b1;
        endcase
    end

    assign crc_fail = rx_frame_end && pkt_cfg_ff[PC_CRC_EN] && !rx_crc_pass;
    assign drop_ev = (rx_addr_valid && !addr_pass)
        || (rx_len_valid && pkt_cfg_ff[PC_LEN_KIND] && rx_len > payload_len_ff);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            queue_clear_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            queue_clear_ff <= drop_ev || (crc_fail && !pkt_cfg_ff[PC_FAIL_KEEP]);
            restart_ff <= drop_ev || (crc_fail && !pkt_cfg_ff[PC_FAIL_KEEP]);
        end
    end

    // Set wins over the clear when the queue empties in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            payload_ff <= 1'b0;
            crc_good_ff <= 1'b0;
        end else begin
            if (rx_frame_end && (!crc_fail || pkt_cfg_ff[PC_FAIL_KEEP])) begin
                payload_ff <= 1'b1;
            end else if (!queue_has_byte || queue_clear_ff) begin
                payload_ff <= 1'b0;
            end
            if (rx_frame_end && pkt_cfg_ff[PC_CRC_EN] && rx_crc_pass) begin
                crc_good_ff <= 1'b1;
            end else if (!queue_has_byte || queue_clear_ff) begin
                crc_good_ff <= 1'b0;
            end
        end
    end

    // Flag history for edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            qhb_prev_ff <= 1'b0;
            over_prev_ff <= 1'b0;
            crc_prev_ff <= 1'b0;
            pc_prev_ff <= 1'b0;
            mark_prev_ff <= 1'b0;
            txd_prev_ff <= 1'b0;
        end else begin
            qhb_prev_ff <= queue_has_byte;
            over_prev_ff <= queue_over_threshold;
            crc_prev_ff <= crc_good_ff;
            pc_prev_ff <= payload_ff;
            mark_prev_ff <= frame_marker_match;
            txd_prev_ff <= tx_frame_done;
        end
    end

    assign ent_code = auto_ctrl_ff[AC_ENT_HI:AC_ENT_LO];
    assign lv_code = auto_ctrl_ff[AC_LV_HI:AC_LV_LO];
    assign auto_on = (ent_code != TRIG_OFF) && (lv_code != TRIG_OFF);

    always_comb begin
        case (ent_code)
            TRIG_QHB_RISE: enter_ev = queue_has_byte && !qhb_prev_ff;
            TRIG_OVER: enter_ev = queue_over_threshold && !over_prev_ff;
            TRIG_CRC: enter_ev = crc_good_ff && !crc_prev_ff;
            TRIG_PAYLOAD: enter_ev = payload_ff && !pc_prev_ff;
            TRIG_MARKER: enter_ev = frame_marker_match && !mark_prev_ff;
            TRIG_TXDONE: enter_ev = tx_frame_done && !txd_prev_ff;
            TRIG_SEVEN: enter_ev = !queue_has_byte && qhb_prev_ff;
            default: enter_ev = 1'b0;
        endcase
        case (lv_code)
            TRIG_QHB_RISE: leave_ev = !queue_has_byte && qhb_prev_ff;
            TRIG_OVER: leave_ev = (queue_over_threshold && !over_prev_ff) || rx_timeout;
            TRIG_CRC: leave_ev = (crc_good_ff && !crc_prev_ff) || rx_timeout;
            TRIG_PAYLOAD: leave_ev = (payload_ff && !pc_prev_ff) || rx_timeout;
            TRIG_MARKER: leave_ev = (frame_marker_match && !mark_prev_ff) || rx_timeout;
            TRIG_TXDONE: leave_ev = tx_frame_done && !txd_prev_ff;
            TRIG_SEVEN: leave_ev = rx_timeout;
            default: leave_ev = 1'b0;
        endcase
    end

    // Auto mode sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            auto_state_ff <= PKH_AUTO_IDLE;
            saved_mode_ff <= RST_OP_MODE;
            op_mode_ff <= RST_OP_MODE;
        end else begin
            case (auto_state_ff)
                PKH_AUTO_IDLE: begin
                    op_mode_ff <= sw_mode_ff;
                    if (auto_on && enter_ev) begin
                        auto_state_ff <= PKH_AUTO_INTERIM;
                        saved_mode_ff <= sw_mode_ff;
                        op_mode_ff <= auto_ctrl_ff[AC_MODE_HI:AC_MODE_LO];
                    end
                end
                PKH_AUTO_INTERIM: begin
                    // Turning the sequencer off also ends the interim stay
                    if (!auto_on || leave_ev) begin
                        auto_state_ff <= PKH_AUTO_IDLE;
                        op_mode_ff <= saved_mode_ff;
                    end
                end
                default: auto_state_ff <= PKH_AUTO_IDLE;
            endcase
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_comb begin
        nxt_irq_st = irq_st_ff;
        if (wr_en && idx == IDX_IRQ_STATUS) begin
            nxt_irq_st = irq_st_ff & ~pwdata[IRQ_W-1:0];
        end
        if (payload_ff && !pc_prev_ff) begin
            nxt_irq_st[IRQ_PAYLOAD] = 1'b1;
        end
        if (crc_fail) begin
            nxt_irq_st[IRQ_CRC_FAIL] = 1'b1;
        end
        if (drop_ev) begin
            nxt_irq_st[IRQ_DROP] = 1'b1;
        end
        if (auto_state_ff == PKH_AUTO_IDLE && auto_on && enter_ev) begin
            nxt_irq_st[IRQ_ENTER] = 1'b1;
        end
        if (auto_state_ff == PKH_AUTO_INTERIM && (!auto_on || leave_ev)) begin
            nxt_irq_st[IRQ_LEAVE] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_st_ff <= '0;
            irq <= 1'b0;
        end else begin
            irq_st_ff <= nxt_irq_st;
            irq <= |(nxt_irq_st & irq_mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign queue_clear = queue_clear_ff;
    assign rx_restart = restart_ff;
    assign rx_payload_complete = payload_ff;
    assign checksum_good = crc_good_ff;
    assign op_mode = op_mode_ff;
    assign auto_interim_active = (auto_state_ff == PKH_AUTO_INTERIM);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_fixed_tx_len: assert property (!pkt_cfg_ff[PC_LEN_KIND] |=> tx_len == $past(payload_len_ff))
        else $error("fixed length not used on transmit");
    a_var_tx_ignore: assert property (pkt_cfg_ff[PC_LEN_KIND] |=> tx_len == 8'h00)
        else $error("length used on variable transmit");
    a_crc_follow: assert property (rstn |=> tx_crc_append == $past(pkt_cfg_ff[PC_CRC_EN]))
        else $error("checksum enable not applied");
    a_fail_clears: assert property (crc_fail && !pkt_cfg_ff[PC_FAIL_KEEP]
        |=> queue_clear && rx_restart && !(payload_ff && !$past(payload_ff)))
        else $error("failed checksum did not clear queue");
    a_fail_keeps: assert property (crc_fail && pkt_cfg_ff[PC_FAIL_KEEP]
        |=> payload_ff ##1 irq_st_ff[IRQ_PAYLOAD])
        else $error("failed checksum with keep lost payload");
    a_own_filter: assert property (rx_addr_valid && pkt_cfg_ff[PC_FILT_HI:PC_FILT_LO] == FILT_OWN
        && rx_addr != station_addr_ff |=> queue_clear)
        else $error("own address filter passed a foreign address");
    a_grp_filter: assert property (rx_addr_valid && !rx_len_valid && !crc_fail
        && pkt_cfg_ff[PC_FILT_HI:PC_FILT_LO] == FILT_OWN_GRP && rx_addr == group_addr_ff
        |=> !queue_clear)
        else $error("group address rejected");
    a_enter_mode: assert property (auto_state_ff == PKH_AUTO_IDLE && auto_on && enter_ev
        |=> auto_interim_active && op_mode == $past(auto_ctrl_ff[AC_MODE_HI:AC_MODE_LO]))
        else $error("interim mode not entered");
    a_off_idle: assert property (!auto_on && !auto_interim_active
        |=> !auto_interim_active && op_mode == $past(sw_mode_ff))
        else $error("sequencer entered while off");
    a_leave_restore: assert property (auto_interim_active && auto_on && leave_ev
        |=> !auto_interim_active && op_mode == $past(saved_mode_ff))
        else $error("mode not restored on leave");
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("bus access not completed");

    c_enter_leave: cover property (!auto_interim_active ##1 auto_interim_active ##[1:50] !auto_interim_active);
    c_crc_fail_keep: cover property (crc_fail && pkt_cfg_ff[PC_FAIL_KEEP]);
    c_addr_drop: cover property (rx_addr_valid && !addr_pass);
    c_irq_raise: cover property (!irq ##1 irq);
endmodule : pkh_packet_handler

`default_nettype wire

// ---- pkh_radio_peer.sv ----
// Purpose: Far-side radio datapath that feeds received bytes and flags to the handler
// Assumes: Handler clears the receive queue through its queue_clear pulse
// Notes: A dropped frame stops early, as the real receiver restarts on a new packet
`timescale 1ns/10ps
`default_nettype none
module pkh_radio_peer (
    input wire logic clk,
    input wire logic queue_clear,
    output logic queue_has_byte,
    output logic queue_over_threshold,
    output logic frame_marker_match,
    output logic tx_frame_done,
    output logic rx_timeout,
    output logic rx_addr_valid,
    output logic [7:0] rx_addr,
    output logic rx_len_valid,
    output logic [7:0] rx_len,
    output logic rx_frame_end,
    output logic rx_crc_pass
);
    int clears = 0;
    initial begin
        {queue_has_byte, queue_over_threshold, frame_marker_match, tx_frame_done} = 4'h0;
        {rx_timeout, rx_addr_valid, rx_len_valid, rx_frame_end, rx_crc_pass} = 5'h00;
        rx_addr = 8'h00;
        rx_len = 8'h00;
    end
    always @(posedge clk) begin
        if (queue_clear === 1'b1) begin
            clears++;
            queue_has_byte <= 1'b0;
        end
    end
    task automatic rx_frame(input logic [7:0] a, input logic [7:0] l, input logic ok);
        int c0;
        c0 = clears;
        @(posedge clk);
        rx_addr <= a;
        rx_addr_valid <= 1'b1;
        queue_has_byte <= 1'b1;
        @(posedge clk);
        rx_addr_valid <= 1'b0;
        rx_addr <= ~a;
        @(posedge clk);
        if (clears == c0 && queue_clear !== 1'b1) begin
            rx_len <= l;
            rx_len_valid <= 1'b1;
            @(posedge clk);
            rx_len_valid <= 1'b0;
            rx_len <= ~l;
            @(posedge clk);
            if (clears == c0 && queue_clear !== 1'b1) begin
                rx_frame_end <= 1'b1;
                rx_crc_pass <= ok;
                @(posedge clk);
                rx_frame_end <= 1'b0;
                rx_crc_pass <= ~ok;
            end
        end
        repeat (3) @(posedge clk);
    endtask : rx_frame
    task automatic set_queue(input logic v);
        @(posedge clk);
        queue_has_byte <= v;
        repeat (3) @(posedge clk);
    endtask : set_queue
    task automatic set_flags(input logic [2:0] f);
        @(posedge clk);
        {queue_over_threshold, frame_marker_match, tx_frame_done} <= f;
        repeat (3) @(posedge clk);
    endtask : set_flags
    task automatic pulse_timeout;
        @(posedge clk);
        rx_timeout <= 1'b1;
        @(posedge clk);
        rx_timeout <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse_timeout
endmodule : pkh_radio_peer
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the packet handler configuration block
// Assumes: One APB wait state; receive traffic comes from the peer model
// Notes: Drop counts are taken from the peer, which sees every queue_clear pulse
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pkh_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, queue_has_byte, queue_over_threshold, frame_marker_match;
    logic tx_frame_done, rx_timeout, rx_addr_valid, rx_len_valid, rx_frame_end, rx_crc_pass;
    logic [7:0] rx_addr, rx_len, tx_len, rx_max_len, rd;
    logic length_kind_select, tx_crc_append, rx_crc_check, queue_clear, rx_restart, err;
    logic rx_payload_complete, checksum_good, auto_interim_active, irq;
    logic [1:0] line_code_select, op_mode;
    int errors = 0, total_checks = 0, c0;
    always #20 clk = ~clk;
    pkh_packet_handler dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .queue_has_byte, .queue_over_threshold, .frame_marker_match,
        .tx_frame_done, .rx_timeout, .rx_addr_valid, .rx_addr, .rx_len_valid, .rx_len,
        .rx_frame_end, .rx_crc_pass, .length_kind_select, .line_code_select, .tx_crc_append,
        .rx_crc_check, .tx_len, .rx_max_len, .queue_clear, .rx_restart, .rx_payload_complete,
        .checksum_good, .op_mode, .auto_interim_active, .irq);
    pkh_radio_peer peer (.clk, .queue_clear, .queue_has_byte, .queue_over_threshold,
        .frame_marker_match, .tx_frame_done, .rx_timeout, .rx_addr_valid, .rx_addr,
        .rx_len_valid, .rx_len, .rx_frame_end, .rx_crc_pass);
    always @(posedge clk) begin
        if (queue_clear === 1'b1 || rx_restart === 1'b1) begin
            chk("restart", {7'h0, queue_clear}, {7'h0, rx_restart});
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input string n, input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(n, e, rd);
    endtask : rchk
    task automatic t_reset;
        rchk("pkt_cfg", IDX_PKT_CFG, RST_PKT_CFG);
        rchk("payload_len", IDX_PAYLOAD_LEN, 8'h40);
        rchk("station", IDX_STATION_ADDR, 8'h00);
        rchk("group", IDX_GROUP_ADDR, 8'h00);
        rchk("auto_ctrl", IDX_AUTO_CTRL, 8'h00);
        chk("tx_len", 8'h40, tx_len);
        apb(1'b0, 8'h00, 8'h00);
        chk("unmapped_err", 8'h01, {7'h0, err});
        $display("test reset done");
    endtask : t_reset
    task automatic t_config;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, IDX_PKT_CFG, {1'b1, i[1:0], 5'h01});
            rchk("cfg_rb", IDX_PKT_CFG, {1'b1, i[1:0], 5'h00});
            chk("line_code", {6'h0, i[1:0]}, {6'h0, line_code_select});
            chk("len_kind", 8'h01, {7'h0, length_kind_select});
            chk("crc_off", 8'h00, {6'h0, tx_crc_append, rx_crc_check});
            chk("tx_len_var", 8'h00, tx_len);
            chk("rx_max", 8'h40, rx_max_len);
        end
        apb(1'b1, IDX_PKT_CFG, 8'h10);
        repeat (2) @(posedge clk);
        chk("crc_on", 8'h03, {6'h0, tx_crc_append, rx_crc_check});
        chk("fixed", 8'h40, {length_kind_select, tx_len[6:0]});
        $display("test config done");
    endtask : t_config
    task automatic t_crc;
        c0 = peer.clears;
        peer.rx_frame(8'h00, 8'h40, 1'b0);
        chk("drop_keep0", 8'h01, 8'(peer.clears - c0));
        chk("pc_keep0", 8'h00, {7'h0, rx_payload_complete});
        rchk("irq_status", IDX_IRQ_STATUS, 8'h02);
        chk("irq_masked", 8'h00, {7'h0, irq});
        apb(1'b1, IDX_IRQ_MASK, 8'h02);
        repeat (3) @(posedge clk);
        chk("irq_on", 8'h01, {7'h0, irq});
        apb(1'b1, IDX_IRQ_STATUS, 8'h02);
        repeat (3) @(posedge clk);
        chk("irq_cleared", 8'h00, {7'h0, irq});
        apb(1'b1, IDX_PKT_CFG, 8'h18);
        c0 = peer.clears;
        peer.rx_frame(8'h00, 8'h40, 1'b0);
        chk("drop_keep1", 8'h00, 8'(peer.clears - c0));
        chk("pc_keep1", 8'h01, {checksum_good, 6'h0, rx_payload_complete});
        peer.set_queue(1'b0);
        $display("test crc done");
    endtask : t_crc
    task automatic frame_drop(input string n, input logic [7:0] a, input logic [7:0] l,
                              input int e);
        c0 = peer.clears;
        peer.rx_frame(a, l, 1'b1);
        chk(n, e[7:0], 8'(peer.clears - c0));
        if (e == 0) begin
            chk("pc_good", 8'h81, {checksum_good, 6'h0, rx_payload_complete});
            peer.set_queue(1'b0);
        end
    endtask : frame_drop
    task automatic t_filter;
        apb(1'b1, IDX_STATION_ADDR, 8'h5a);
        apb(1'b1, IDX_GROUP_ADDR, 8'ha5);
        apb(1'b1, IDX_PKT_CFG, 8'h12);
        frame_drop("own_grp", 8'ha5, 8'h40, 1);
        frame_drop("own_ok", 8'h5a, 8'h40, 0);
        apb(1'b1, IDX_PKT_CFG, 8'h14);
        frame_drop("grp_ok", 8'ha5, 8'h40, 0);
        frame_drop("grp_other", 8'h33, 8'h40, 1);
        apb(1'b1, IDX_PKT_CFG, 8'h16);
        frame_drop("filt_rsv", 8'h33, 8'h40, 0);
        apb(1'b1, IDX_PKT_CFG, 8'h90);
        apb(1'b1, IDX_PAYLOAD_LEN, 8'h10);
        frame_drop("len_over", 8'h00, 8'h11, 1);
        frame_drop("len_max", 8'h00, 8'h10, 0);
        $display("test filter done");
    endtask : t_filter
    task automatic t_auto;
        apb(1'b1, IDX_OP_MODE, 8'h00);
        apb(1'b1, IDX_AUTO_CTRL, 8'h26);
        peer.set_queue(1'b1);
        chk("enter_rx", 8'h06, {5'h0, auto_interim_active, op_mode});
        peer.set_queue(1'b0);
        chk("leave_qhb", 8'h00, {5'h0, auto_interim_active, op_mode});
        apb(1'b1, IDX_AUTO_CTRL, 8'hff);
        peer.set_queue(1'b1);
        chk("no_enter", 8'h00, {5'h0, auto_interim_active, op_mode});
        peer.set_queue(1'b0);
        chk("enter_tx", 8'h07, {5'h0, auto_interim_active, op_mode});
        peer.pulse_timeout();
        chk("leave_tmo", 8'h00, {5'h0, auto_interim_active, op_mode});
        apb(1'b1, IDX_AUTO_CTRL, 8'h5b);
        peer.set_flags(3'b100);
        chk("enter_over", 8'h07, {5'h0, auto_interim_active, op_mode});
        peer.set_flags(3'b001);
        chk("leave_txd", 8'h00, {5'h0, auto_interim_active, op_mode});
        apb(1'b1, IDX_AUTO_CTRL, 8'hb6);
        peer.set_flags(3'b010);
        chk("enter_mark", 8'h06, {5'h0, auto_interim_active, op_mode});
        peer.pulse_timeout();
        chk("leave_tmo2", 8'h00, {5'h0, auto_interim_active, op_mode});
        peer.set_flags(3'b000);
        apb(1'b1, IDX_AUTO_CTRL, 8'h21);
        peer.set_queue(1'b1);
        chk("seq_off", 8'h00, {5'h0, auto_interim_active, op_mode});
        peer.set_queue(1'b0);
        $display("test auto done");
    endtask : t_auto
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_config();
        t_crc();
        t_filter();
        t_auto();
        close_out();
    end
endmodule : tb
`default_nettype wire
